// ---- include/cpc_consts.svh ----
// Purpose: offsets, field positions, reset values and counts of the codec port control block
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef CPC_CONSTS_SVH
`define CPC_CONSTS_SVH
// ==========================================================
// direct register offsets
`define CPC_OFS_GO        2'h0
`define CPC_OFS_MODE      2'h1
`define CPC_OFS_PTR       2'h2
`define CPC_OFS_IDATA     2'h3
// ==========================================================
// field positions and reset values
`define CPC_GO_BIT        0
`define CPC_REV_LSB       4
`define CPC_GO_RST        1'h0
`define CPC_MODE_RST      8'h91
`define CPC_DIR_BIT       7
`define CPC_SETUP1_IDX    4'h0
`define CPC_SETUP1_RST    8'h01
`define CPC_SEQ_BIT       0
`define CPC_IND_NUM       12
`define CPC_PTR_MAX       4'hB
// ==========================================================
// timing and sizes
`define CPC_RST_EXTRA     2'h2
`define CPC_FIFO_DEPTH    16
`define CPC_FIFO_WIDTH    8
`endif

// ---- include/cpc_pkg.sv ----
// Purpose: types shared by the codec port control block
// Assumes: cpc_consts.svh on the include path
// Notes:   all core state except the fifo lives in one packed struct
`include "cpc_consts.svh"
package cpc_pkg;
  // ==========================================================
  // frame sequencer
  typedef enum logic [2:0] {
    CPC_IDLE  = 3'b001,
    CPC_ARMED = 3'b010,
    CPC_BUSY  = 3'b100
  } cpc_state_t;

  // ==========================================================
  // core state
  typedef struct packed {
    logic [1:0]                        rst_cnt;
    logic                              in_rst;
    logic                              go;
    logic [7:0]                        mode;
    logic [3:0]                        ptr;
    logic                              ptr_loaded;
    logic [`CPC_IND_NUM-1:0][7:0]      ind;
    logic                              wr_d;
    logic                              rd_d;
    logic                              start_d;
    logic                              fen_d;
    cpc_state_t                        st;
    logic                              drain;
    logic [7:0]                        dout;
    logic                              dout_oe_n;
    logic [23:0]                       pix_out;
    logic                              pix_oe_n;
    logic                              len_out;
    logic                              fen_out;
    logic                              window;
    logic                              fbusy;
    logic                              cbusy;
    logic                              accept;
    logic [7:0]                        blk_out;
    logic                              blk_oe_n;
    logic                              sync_out;
    logic                              eos_out;
    logic                              stop_out;
    logic                              stop_oe_n;
  } cpc_core_t;
endpackage : cpc_pkg

// ---- core/cpc_codec_ctrl.sv ----
// Purpose: host registers, frame start logic and codec port of the pixel pre/post-processor
// Assumes: all inputs synchronous to mclk, srst synchronous active high
// Notes:   strip buffer sequencing and format datapaths are not part of this block
`timescale 1ns/1ps
`include "cpc_consts.svh"

// ==========================================================
// fifo
module cpc_fifo #(
  parameter int W = `CPC_FIFO_WIDTH,
  parameter int D = `CPC_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } cpc_fifo_st_t;

  cpc_fifo_st_t f_r;
  cpc_fifo_st_t f_nxt;
  logic         push;
  logic         pop;

  assign in_ready  = (f_r.cnt != D[AW:0]);
  assign out_valid = (f_r.cnt != '0);
  assign out_data  = f_r.mem[f_r.rp];

  always_comb
  begin
    f_nxt = f_r;
    push  = in_valid & in_ready;
    pop   = out_valid & out_ready;
    if (push)
    begin
      f_nxt.mem[f_r.wp] = in_data;
      f_nxt.wp = (f_r.wp == AW'(D - 1)) ? '0 : f_r.wp + 1'b1;
    end
    if (pop)
    begin
      f_nxt.rp = (f_r.rp == AW'(D - 1)) ? '0 : f_r.rp + 1'b1;
    end
    if (push && !pop)
    begin
      f_nxt.cnt = f_r.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      f_nxt.cnt = f_r.cnt - 1'b1;
    end
    if (rst)
    begin
      f_nxt.wp  = '0;
      f_nxt.rp  = '0;
      f_nxt.cnt = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      f_r <= f_nxt;
    end
  end
endmodule : cpc_fifo

// ==========================================================
// top
module cpc_codec_ctrl #(
  parameter logic [3:0] REVISION = 4'h0
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic [1:0]  host_addr,
  input  wire logic [7:0]  host_data_in,
  output logic [7:0]       host_data_out,
  output logic             host_data_oe_n,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic        host_cs,
  input  wire logic        start_in,
  output logic             frame_busy,
  output logic             window_active,
  input  wire logic [23:0] pixel_in_bus,
  input  wire logic        pixel_out_drive_enable,
  output logic [23:0]      pixel_out_bus,
  output logic             pixel_out_oe_n,
  input  wire logic        line_enable_in,
  input  wire logic        frame_enable_in,
  output logic             line_enable_out,
  output logic             frame_enable_out,
  output logic             pixel_accept,
  output logic             codec_busy,
  output logic             buffer_write_enable,
  output logic             buffer_output_enable,
  output logic [15:0]      buffer_address,
  input  wire logic        codec_compress_in,
  input  wire logic [7:0]  block_bus_in,
  output logic [7:0]       block_bus_out,
  output logic             block_bus_oe_n,
  input  wire logic        block_sync_in,
  output logic             block_sync_out,
  output logic             block_sync_oe_n,
  input  wire logic        end_of_scan_in,
  output logic             end_of_scan_out,
  output logic             end_of_scan_oe_n,
  input  wire logic        flow_stop_in,
  output logic             flow_stop_out,
  output logic             flow_stop_oe_n
);
  cpc_pkg::cpc_core_t s_r;
  cpc_pkg::cpc_core_t s_nxt;
  logic               rst_all;
  logic               rd_act;
  logic               wr_rise;
  logic               rd_fall;
  logic               locked;
  logic               seq;
  logic               cmp;
  logic               in_win;
  logic               launch;
  logic               begin_frm;
  logic               end_frm;
  logic               f_in_valid;
  logic [7:0]         f_in_data;
  logic               f_in_ready;
  logic               f_out_valid;
  logic [7:0]         f_out_data;
  logic               f_out_ready;
  logic               fifo_rst;

  // ==========================================================
  // helpers
  function automatic logic [3:0] ptr_step(input logic [3:0] p);
    ptr_step = (p >= `CPC_PTR_MAX) ? `CPC_PTR_MAX : p + 4'h1;
  endfunction : ptr_step

  function automatic logic [7:0] rd_mux(input cpc_pkg::cpc_core_t s,
                                        input logic [1:0] a);
    case (a)
      `CPC_OFS_GO:   rd_mux = {REVISION, 3'h0, s.go};
      `CPC_OFS_MODE: rd_mux = s.mode;
      `CPC_OFS_PTR:  rd_mux = {4'h0, s.ptr};
      default:       rd_mux = s.ind[s.ptr];
    endcase
  endfunction : rd_mux

  // ==========================================================
  // stream buffer between pixel side and codec side
  assign fifo_rst = srst | s_r.in_rst;

  cpc_fifo #(
    .W (`CPC_FIFO_WIDTH),
    .D (`CPC_FIFO_DEPTH)
  ) u_fifo (
    .clk       (mclk),
    .rst       (fifo_rst),
    .ce        (ce),
    .in_valid  (f_in_valid),
    .in_data   (f_in_data),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (f_out_ready)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    s_nxt   = s_r;
    rst_all = srst | s_r.in_rst;
    rd_act  = host_cs & host_rd;
    wr_rise = host_cs & host_wr & ~s_r.wr_d;
    rd_fall = s_r.rd_d & ~rd_act;
    locked  = s_r.fbusy;
    seq     = s_r.ind[`CPC_SETUP1_IDX][`CPC_SEQ_BIT];
    cmp     = s_r.mode[`CPC_DIR_BIT];
    in_win  = (s_r.st == cpc_pkg::CPC_BUSY) & line_enable_in & frame_enable_in;
    launch  = seq ? start_in : (start_in & ~s_r.start_d);
    begin_frm = cmp ? (frame_enable_in & ~s_r.fen_d)
                    : (block_sync_in & ~codec_compress_in);
    end_frm   = cmp ? (~frame_enable_in & s_r.fen_d)
                    : (end_of_scan_in & ~codec_compress_in);

    // edge trackers
    s_nxt.wr_d    = host_cs & host_wr;
    s_nxt.rd_d    = rd_act;
    s_nxt.start_d = start_in;
    s_nxt.fen_d   = frame_enable_in;

    // ----------------------------------------------------------
    // frame sequencer
    case (s_r.st)
      cpc_pkg::CPC_IDLE:
      begin
        if (s_r.go && launch)
        begin
          s_nxt.st = cpc_pkg::CPC_ARMED;
        end
      end
      cpc_pkg::CPC_ARMED:
      begin
        if (!s_r.go || (seq && !start_in))
        begin
          s_nxt.st = cpc_pkg::CPC_IDLE;
        end
        else if (begin_frm)
        begin
          s_nxt.st = cpc_pkg::CPC_BUSY;
        end
      end
      cpc_pkg::CPC_BUSY:
      begin
        if (end_frm)
        begin
          s_nxt.st    = cpc_pkg::CPC_IDLE;
          s_nxt.drain = cmp;
          if (!seq)
          begin
            s_nxt.go = 1'b0;
          end
        end
      end
      default:
      begin
        s_nxt.st = cpc_pkg::CPC_IDLE;
      end
    endcase

    // ----------------------------------------------------------
    // host writes; a host write of go comes after the self clear so a set wins
    if (wr_rise)
    begin
      case (host_addr)
        `CPC_OFS_GO:
        begin
          s_nxt.go = host_data_in[`CPC_GO_BIT];
        end
        `CPC_OFS_MODE:
        begin
          if (!locked)
          begin
            s_nxt.mode = host_data_in;
          end
        end
        `CPC_OFS_PTR:
        begin
          if (!locked)
          begin
            s_nxt.ptr = (host_data_in > {4'h0, `CPC_PTR_MAX}) ? `CPC_PTR_MAX
                                                              : host_data_in[3:0];
            s_nxt.ptr_loaded = 1'b1;
          end
        end
        default:
        begin
          if (!locked)
          begin
            s_nxt.ind[s_r.ptr] = host_data_in;
            if (s_r.ptr_loaded)
            begin
              s_nxt.ptr = ptr_step(s_r.ptr);
            end
          end
        end
      endcase
    end

    // pointer advances once a read of indirect data ends
    if (rd_fall && (host_addr == `CPC_OFS_IDATA) && !locked && s_r.ptr_loaded)
    begin
      s_nxt.ptr = ptr_step(s_r.ptr);
    end

    // host read path keeps working through reset
    s_nxt.dout_oe_n = ~rd_act;
    if (rd_act)
    begin
      s_nxt.dout = rd_mux(s_r, host_addr);
    end

    // ----------------------------------------------------------
    // pixel side, sampled on mclk as the pixel timing reference
    s_nxt.pix_out  = pixel_in_bus;
    s_nxt.pix_oe_n = ~pixel_out_drive_enable;
    s_nxt.len_out  = line_enable_in;
    s_nxt.fen_out  = frame_enable_in;
    s_nxt.window   = in_win;
    s_nxt.fbusy    = (s_nxt.st == cpc_pkg::CPC_BUSY);
    s_nxt.accept   = f_in_ready;
    s_nxt.cbusy    = (s_r.st == cpc_pkg::CPC_BUSY) & ~f_in_ready;

    // ----------------------------------------------------------
    // codec side direction follows the codec's own indicator, even in reset
    s_nxt.blk_oe_n  = ~codec_compress_in;
    s_nxt.stop_oe_n = codec_compress_in;
    // stop is asserted one word early is not possible with a registered flag,
    // so pushes are gated by ready as well and excess codec bytes are lost
    s_nxt.stop_out  = ~f_in_ready;

    f_in_valid  = 1'b0;
    f_in_data   = pixel_in_bus[7:0];
    f_out_ready = 1'b0;
    s_nxt.sync_out = 1'b0;
    s_nxt.eos_out  = 1'b0;
    if (cmp)
    begin
      f_in_valid  = in_win;
      f_out_ready = codec_compress_in & ~flow_stop_in;
      if (f_out_valid && f_out_ready)
      begin
        s_nxt.blk_out  = f_out_data;
        s_nxt.sync_out = 1'b1;
      end
      if (s_r.drain && !f_out_valid)
      begin
        s_nxt.eos_out = 1'b1;
        s_nxt.drain   = 1'b0;
      end
    end
    else
    begin
      f_in_valid  = (s_r.st == cpc_pkg::CPC_BUSY) & ~codec_compress_in & ~s_r.stop_out;
      f_in_data   = block_bus_in;
      f_out_ready = in_win;
      s_nxt.drain = 1'b0;
      if (f_out_valid && in_win)
      begin
        s_nxt.pix_out[7:0] = f_out_data;
      end
    end

    // ----------------------------------------------------------
    // reset: control state cleared, held two more cycles after release
    if (srst)
    begin
      s_nxt.rst_cnt = `CPC_RST_EXTRA;
      s_nxt.in_rst  = 1'b1;
    end
    else if (s_r.rst_cnt != 2'h0)
    begin
      s_nxt.rst_cnt = s_r.rst_cnt - 2'h1;
      s_nxt.in_rst  = (s_r.rst_cnt != 2'h1);
    end
    if (rst_all)
    begin
      s_nxt.go         = `CPC_GO_RST;
      s_nxt.mode       = `CPC_MODE_RST;
      s_nxt.ptr        = 4'h0;
      s_nxt.ptr_loaded = 1'b0;
      s_nxt.ind        = '0;
      s_nxt.ind[`CPC_SETUP1_IDX] = `CPC_SETUP1_RST;
      s_nxt.st         = cpc_pkg::CPC_IDLE;
      s_nxt.drain      = 1'b0;
      s_nxt.len_out    = 1'b1;
      s_nxt.fen_out    = 1'b1;
      s_nxt.cbusy      = 1'b1;
      s_nxt.window     = 1'b0;
      s_nxt.fbusy      = 1'b0;
      s_nxt.sync_out   = 1'b0;
      s_nxt.eos_out    = 1'b0;
      s_nxt.blk_out    = 8'h00;
      s_nxt.accept     = 1'b0;
    end
  end

  // ==========================================================
  // state register; ce low freezes everything, reset included
  always_ff @(posedge mclk)
  begin
    if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs, straight from the state register
  assign host_data_out        = s_r.dout;
  assign host_data_oe_n       = s_r.dout_oe_n;
  assign frame_busy           = s_r.fbusy;
  assign window_active        = s_r.window;
  assign pixel_out_bus        = s_r.pix_out;
  assign pixel_out_oe_n       = s_r.pix_oe_n;
  assign line_enable_out      = s_r.len_out;
  assign frame_enable_out     = s_r.fen_out;
  assign pixel_accept         = s_r.accept;
  assign codec_busy           = s_r.cbusy;
  // strip buffer is not sequenced here; strobes rest inactive high
  assign buffer_write_enable  = s_r.in_rst | ~s_r.in_rst;
  assign buffer_output_enable = s_r.in_rst | ~s_r.in_rst;
  assign buffer_address       = {16{s_r.in_rst & ~s_r.in_rst}};
  assign block_bus_out        = s_r.blk_out;
  assign block_bus_oe_n       = s_r.blk_oe_n;
  assign block_sync_out       = s_r.sync_out;
  assign block_sync_oe_n      = s_r.blk_oe_n;
  assign end_of_scan_out      = s_r.eos_out;
  assign end_of_scan_oe_n     = s_r.blk_oe_n;
  assign flow_stop_out        = s_r.stop_out;
  assign flow_stop_oe_n       = s_r.stop_oe_n;
endmodule : cpc_codec_ctrl

// ---- dv/cpc_codec_ctrl_assertions.sv ----
// Purpose: port checker for cpc_codec_ctrl
// Assumes: bench holds ce high
// Notes:   bound to every cpc_codec_ctrl instance
`timescale 1ns/1ps

module cpc_codec_ctrl_assertions (
  input logic        mclk,
  input logic        srst,
  input logic        ce,
  input logic        host_cs,
  input logic        host_rd,
  input logic        host_data_oe_n,
  input logic [23:0] pixel_in_bus,
  input logic [23:0] pixel_out_bus,
  input logic        pixel_accept,
  input logic        frame_busy,
  input logic        window_active,
  input logic        pixel_out_drive_enable,
  input logic        pixel_out_oe_n,
  input logic        line_enable_in,
  input logic        frame_enable_in,
  input logic        line_enable_out,
  input logic        frame_enable_out,
  input logic        codec_busy,
  input logic        buffer_write_enable,
  input logic        buffer_output_enable,
  input logic [15:0] buffer_address,
  input logic        codec_compress_in,
  input logic        block_bus_oe_n,
  input logic        block_sync_oe_n,
  input logic        block_sync_in,
  input logic        block_sync_out,
  input logic        end_of_scan_in,
  input logic        end_of_scan_oe_n,
  input logic        end_of_scan_out,
  input logic        flow_stop_oe_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // ==========
  // reset
  // the reset level check must run while srst is high, so only ce gates it
  a_rst_levels: assert property (disable iff (!ce) srst |=>
    line_enable_out && frame_enable_out && codec_busy && buffer_write_enable
    && buffer_output_enable && !window_active && !frame_busy && buffer_address == 16'h0000)
    else $error("reset output levels wrong");
  a_rst_tail: assert property ($fell(srst) |-> codec_busy ##1 codec_busy && !frame_busy)
    else $error("internal reset ended early");

  // ==========
  // codec port direction
  a_dir_drive: assert property (disable iff (!ce) codec_compress_in |=>
    !block_bus_oe_n && !block_sync_oe_n && !end_of_scan_oe_n && flow_stop_oe_n)
    else $error("codec pins not driven in compression");
  a_dir_receive: assert property (disable iff (!ce) !codec_compress_in |=>
    block_bus_oe_n && block_sync_oe_n && end_of_scan_oe_n && !flow_stop_oe_n)
    else $error("codec pins not released in expansion");

  // ==========
  // pixel side and frame
  a_pix_enable: assert property (pixel_out_oe_n == !$past(pixel_out_drive_enable))
    else $error("pixel output enable not following input");
  a_pix_follow: assert property (pixel_out_bus[23:8] == $past(pixel_in_bus[23:8])
    && (window_active || pixel_out_bus[7:0] == $past(pixel_in_bus[7:0])))
    else $error("pixel output not following input outside window");
  a_read_drive: assert property (host_data_oe_n == !$past(host_cs && host_rd))
    else $error("host data enable not following read");
  a_accept_stop: assert property (codec_busy |-> !pixel_accept)
    else $error("pixel accept while codec busy");
  a_eos_pulse: assert property (end_of_scan_out |=> !end_of_scan_out)
    else $error("end of scan longer than one cycle");
  a_sync_driven: assert property (block_sync_out |-> !block_sync_oe_n)
    else $error("block sync pulse while pin released");
  a_win_inside: assert property (window_active |-> $past(line_enable_in && frame_enable_in))
    else $error("window outside enables");
  a_busy_begin: assert property ($rose(frame_busy) |->
    $past(frame_enable_in) || $past(block_sync_in))
    else $error("frame busy without start event");
  a_busy_end: assert property ($fell(frame_busy) |->
    !$past(frame_enable_in) || $past(end_of_scan_in))
    else $error("frame busy ended without frame end");

  c_frame: cover property ($rose(frame_busy));
  c_sync: cover property (block_sync_out);
  c_eos: cover property (end_of_scan_out);
  c_window: cover property (window_active);
endmodule : cpc_codec_ctrl_assertions

bind cpc_codec_ctrl cpc_codec_ctrl_assertions u_cpc_codec_ctrl_assertions (.*);

// ---- dv/cpc_codec_model.sv ----
// Purpose: behavioural codec on the far side of the block port
// Assumes: bench picks direction, stalls and when to send; the model counts the bytes up
// Notes:   lines the codec does not drive toggle, so stale bytes never look good
`timescale 1ns/1ps

module cpc_codec_model (
  input  logic       mclk,
  input  logic       compress,
  input  logic       stall,
  input  logic       send,
  input  logic       end_of_scan,
  input  logic [7:0] block_bus_out,
  input  logic       block_sync_out,
  input  logic       flow_stop_out,
  output logic       codec_compress_in,
  output logic [7:0] block_bus_in,
  output logic       block_sync_in,
  output logic       end_of_scan_in,
  output logic       flow_stop_in,
  output logic [7:0] rx_last
);
  logic [7:0] tx_byte;

  assign codec_compress_in = compress;

  initial
  begin
    {block_bus_in, tx_byte, rx_last} = 24'h000000;
    {block_sync_in, end_of_scan_in, flow_stop_in} = 3'h0;
  end

  always @(posedge mclk)
  begin
    block_bus_in   <= ~block_bus_in;
    block_sync_in  <= compress & ~block_sync_in;
    end_of_scan_in <= compress & ~end_of_scan_in;
    flow_stop_in   <= ~flow_stop_in;
    if (compress)
    begin
      flow_stop_in <= stall;
      if (block_sync_out)
        rx_last <= block_bus_out;
    end
    else if (end_of_scan)
      end_of_scan_in <= 1'b1;
    else if (send && !flow_stop_out)
    begin
      block_bus_in  <= tx_byte;
      block_sync_in <= 1'b1;
      tx_byte       <= tx_byte + 8'h01;
    end
  end
endmodule : cpc_codec_model

// ---- dv/cpc_codec_ctrl_test.sv ----
// Purpose: self-checking bench for cpc_codec_ctrl
// Assumes: ce tied high, single clock
// Notes:   random bytes from a fixed seed
`timescale 1ns/1ps
`include "cpc_consts.svh"

module cpc_codec_ctrl_test;
  // arbitrary revision so read-only bits are not all zero
  localparam logic [3:0] REV = 4'hA;
  logic        mclk, srst, ce, host_wr, host_rd, host_cs, start_in, host_data_oe_n;
  logic [1:0]  host_addr;
  logic [7:0]  host_data_in, host_data_out, block_bus_out, block_bus_in, rx_last, pix_byte;
  logic [23:0] pixel_in_bus, pixel_out_bus;
  logic [15:0] buffer_address;
  logic        frame_busy, window_active, pixel_out_drive_enable, pixel_out_oe_n;
  logic        line_enable_in, frame_enable_in, line_enable_out, frame_enable_out;
  logic        pixel_accept, codec_busy, buffer_write_enable, buffer_output_enable;
  logic        codec_compress_in, block_bus_oe_n, block_sync_in, block_sync_out;
  logic        block_sync_oe_n, end_of_scan_in, end_of_scan_out, end_of_scan_oe_n;
  logic        flow_stop_in, flow_stop_out, flow_stop_oe_n, compress, stall, send, end_of_scan;
  logic [7:0]  exp_ind [12];
  logic [31:0] rnd, prnd;
  integer      seed = 91958;
  int          failures, tests_run, i;

  cpc_codec_ctrl #(.REVISION(REV)) u_cpc_codec_ctrl (.*);
  cpc_codec_model u_cpc_codec_model (.mclk(mclk), .compress(compress), .stall(stall),
    .send(send), .end_of_scan(end_of_scan), .block_bus_out(block_bus_out), .block_sync_out(block_sync_out),
    .flow_stop_out(flow_stop_out), .codec_compress_in(codec_compress_in),
    .block_bus_in(block_bus_in), .block_sync_in(block_sync_in),
    .end_of_scan_in(end_of_scan_in), .flow_stop_in(flow_stop_in), .rx_last(rx_last));

  always #20 mclk = ~mclk;

  always @(posedge mclk)
  begin
    prnd = $random(seed);
    pixel_in_bus           <= {prnd[23:8], pix_byte};
    pixel_out_drive_enable <= prnd[31];
  end

  // ==========
  // helpers
  function automatic logic [7:0] go_byte(input logic g);
    return {REV, 3'h0, g};
  endfunction : go_byte

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic hw(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    {host_cs, host_wr, host_addr, host_data_in} <= {2'b11, a, d};
    @(posedge mclk);
    {host_cs, host_wr} <= 2'b00;
  endtask : hw

  task automatic hr(input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk);
    {host_cs, host_rd, host_addr} <= {2'b11, a};
    repeat (2) @(posedge mclk);
    chk(host_data_out, e);
    {host_cs, host_rd} <= 2'b00;
  endtask : hr

  task automatic do_reset;
    srst <= 1'b1;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : do_reset

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (frame_busy !== v && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
    chk({7'h0, frame_busy}, {7'h0, v});
  endtask : wait_busy

  // no fixed latency here: long enough for a wrongly started frame to show
  task automatic idle_check;
    repeat (8) @(posedge mclk);
    chk({7'h0, frame_busy}, 8'h00);
  endtask : idle_check

  task automatic cfg(input logic [7:0] m, input logic seq);
    hw(`CPC_OFS_PTR, 8'h00);
    hw(`CPC_OFS_IDATA, {7'h00, seq});
    hw(`CPC_OFS_MODE, m);
    hw(`CPC_OFS_GO, 8'h01);
  endtask : cfg

  task automatic tally_and_finish;
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // ==========
  // scenarios
  initial
  begin
    {mclk, srst, ce, host_wr, host_rd, host_cs, start_in} = 7'b0110000;
    {line_enable_in, frame_enable_in, host_addr, host_data_in} = 12'h000;
    {pixel_in_bus, pixel_out_drive_enable, pix_byte} = 33'h0;
    {compress, stall, send, end_of_scan} = 4'b1000;
    do_reset;
    hr(`CPC_OFS_GO, go_byte(1'b0));
    hr(`CPC_OFS_MODE, `CPC_MODE_RST);
    hr(`CPC_OFS_IDATA, `CPC_SETUP1_RST);
    hr(`CPC_OFS_PTR, 8'h00);
    hw(`CPC_OFS_GO, 8'hF0);
    hr(`CPC_OFS_GO, go_byte(1'b0));
    rnd = $random(seed);
    hw(`CPC_OFS_MODE, rnd[7:0]);
    hr(`CPC_OFS_MODE, rnd[7:0]);
    do_reset;
    hr(`CPC_OFS_MODE, `CPC_MODE_RST);
    hw(`CPC_OFS_PTR, 8'h00);
    for (i = 0; i < 14; i++)
    begin
      rnd = $random(seed);
      exp_ind[(i > 11) ? 11 : i] = rnd[7:0];
      hw(`CPC_OFS_IDATA, rnd[7:0]);
    end
    hr(`CPC_OFS_PTR, {4'h0, `CPC_PTR_MAX});
    hw(`CPC_OFS_PTR, 8'h35);
    hr(`CPC_OFS_PTR, {4'h0, `CPC_PTR_MAX});
    hw(`CPC_OFS_PTR, 8'h00);
    for (i = 0; i < 12; i++)
      hr(`CPC_OFS_IDATA, exp_ind[i]);
    // single frame compression, codec stalls first
    rnd = $random(seed);
    pix_byte <= rnd[7:0];
    cfg({1'b1, rnd[14:8]}, 1'b0);
    {stall, start_in} <= 2'b11;
    repeat (2) @(posedge mclk);
    {frame_enable_in, line_enable_in} <= 2'b11;
    wait_busy(1'b1);
    hw(`CPC_OFS_MODE, 8'h00);
    hr(`CPC_OFS_GO, go_byte(1'b1));
    stall <= 1'b0;
    repeat (12) @(posedge mclk);
    {frame_enable_in, line_enable_in} <= 2'b00;
    wait_busy(1'b0);
    hr(`CPC_OFS_GO, go_byte(1'b0));
    hr(`CPC_OFS_MODE, {1'b1, rnd[14:8]});
    chk(rx_last, pix_byte);
    start_in <= 1'b0;
    @(posedge mclk);
    start_in <= 1'b1;
    repeat (2) @(posedge mclk);
    frame_enable_in <= 1'b1;
    idle_check;
    {frame_enable_in, start_in} <= 2'b00;
    // sequential frames gated by start level
    cfg(`CPC_MODE_RST, 1'b1);
    start_in <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      repeat (2) @(posedge mclk);
      frame_enable_in <= 1'b1;
      wait_busy(1'b1);
      rnd = $random(seed);
      repeat (rnd[3:0]) @(posedge mclk);
      frame_enable_in <= 1'b0;
      wait_busy(1'b0);
      hr(`CPC_OFS_GO, go_byte(1'b1));
    end
    start_in <= 1'b0;
    repeat (2) @(posedge mclk);
    frame_enable_in <= 1'b1;
    idle_check;
    {frame_enable_in, start_in} <= 2'b01;
    hw(`CPC_OFS_GO, 8'h00);
    repeat (2) @(posedge mclk);
    frame_enable_in <= 1'b1;
    idle_check;
    // single frame expansion, codec feeds bytes
    cfg(8'h11, 1'b0);
    {compress, start_in, frame_enable_in, line_enable_in} <= 4'b0011;
    @(posedge mclk);
    start_in <= 1'b1;
    repeat (2) @(posedge mclk);
    send <= 1'b1;
    wait_busy(1'b1);
    repeat (20) @(posedge mclk);
    {send, end_of_scan} <= 2'b01;
    @(posedge mclk);
    end_of_scan <= 1'b0;
    wait_busy(1'b0);
    hr(`CPC_OFS_GO, go_byte(1'b0));
    tally_and_finish;
  end

  // tests need under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    failures++;
    tally_and_finish;
  end
endmodule : cpc_codec_ctrl_test
